// [dv/prc_coordinator_chk.sv]
// Port checker for the request coordinator, attached by bind.
// Assumes next-ok inputs are one-cycle pulses on core_clk.
`timescale 1ns/100ps
module prc_coordinator_chk #(
  parameter logic [4:0] WS_BASE_CODE  = 5'h14,
  parameter logic [4:0] HOT_BASE_CODE = 5'h00
) (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        proc_addr_valid,
  input wire logic        proc_addr_ok,
  input wire logic        proc_ready_n,
  input wire logic        map_swap,
  input wire logic        map_swapped,
  input wire logic [31:0] module_addr,
  input wire logic        module_write,
  input wire logic        hotline_mem_request_n,
  input wire logic        hotline_mem_next_ok,
  input wire logic        global_bus_request_n,
  input wire logic        global_bus_next_ok,
  input wire logic        subsystem_request_n,
  input wire logic        subsystem_next_ok,
  input wire logic        workstation_if_request_n,
  input wire logic        workstation_if_next_ok
);
  logic [3:0] req_n;
  logic       ack;
  logic [2:0] held_reg;

  assign req_n = {hotline_mem_request_n, global_bus_request_n, subsystem_request_n,
                  workstation_if_request_n};
  assign ack = |(~req_n & {hotline_mem_next_ok, global_bus_next_ok, subsystem_next_ok,
                           workstation_if_next_ok});

  // Outstanding count seen only from the ports
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      held_reg <= 3'h0;
    else
      held_reg <= held_reg + 3'(proc_addr_valid & proc_addr_ok) - 3'(ack);
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_one_req; $countones(~req_n) <= 1; endproperty
  property p_hot_map; !hotline_mem_request_n |-> module_addr[31:27] == HOT_BASE_CODE; endproperty
  property p_sub_map; !subsystem_request_n |-> module_addr[31:29] == 3'h6; endproperty
  property p_ws_map;
    !workstation_if_request_n |-> (module_addr[31:27] & prc_pkg::QUARTER_MASK) == WS_BASE_CODE;
  endproperty
  property p_hold; (req_n != 4'hf) && !ack |=> $stable(req_n) && $stable(module_addr); endproperty
  property p_rdy_other; ack && module_write |=> !proc_ready_n; endproperty
  property p_rdy_hot;
    !hotline_mem_request_n && hotline_mem_next_ok && !module_write |-> ##2 !proc_ready_n;
  endproperty
  property p_rdy_bus;
    !global_bus_request_n && global_bus_next_ok && !module_write |-> ##3 !proc_ready_n;
  endproperty
  property p_max3; held_reg <= 3'h3; endproperty
  property p_swap; map_swap || map_swapped |=> map_swapped; endproperty

  a_one_req: assert property (p_one_req) else $error("two module requests");
  a_hot_map: assert property (p_hot_map) else $error("hotline decode");
  a_sub_map: assert property (p_sub_map) else $error("subsystem decode");
  a_ws_map: assert property (p_ws_map) else $error("interface decode");
  a_hold: assert property (p_hold) else $error("request dropped early");
  a_rdy_other: assert property (p_rdy_other) else $error("write ready late");
  a_rdy_hot: assert property (p_rdy_hot) else $error("hotline read ready");
  a_rdy_bus: assert property (p_rdy_bus) else $error("bus read ready");
  a_max3: assert property (p_max3) else $error("more than three held");
  a_swap: assert property (p_swap) else $error("swap not sticky");
  c_hot: cover property (p_rdy_hot);
  c_full: cover property (held_reg == 3'h3);
  c_swap: cover property ($rose(map_swapped));
endmodule : prc_coordinator_chk

bind prc_coordinator prc_coordinator_chk #(
  .WS_BASE_CODE(WS_BASE_CODE), .HOT_BASE_CODE(HOT_BASE_CODE)
) u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .proc_addr_valid(proc_addr_valid),
  .proc_addr_ok(proc_addr_ok), .proc_ready_n(proc_ready_n), .map_swap(map_swap),
  .map_swapped(map_swapped), .module_addr(module_addr), .module_write(module_write),
  .hotline_mem_request_n(hotline_mem_request_n), .hotline_mem_next_ok(hotline_mem_next_ok),
  .global_bus_request_n(global_bus_request_n), .global_bus_next_ok(global_bus_next_ok),
  .subsystem_request_n(subsystem_request_n), .subsystem_next_ok(subsystem_next_ok),
  .workstation_if_request_n(workstation_if_request_n),
  .workstation_if_next_ok(workstation_if_next_ok)
);

// [dv/prc_coordinator_tb_top.sv]
// Self-checking bench for the request coordinator with four target models.
// Assumes the coordinator's default region parameters.
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); end end
module prc_coordinator_tb_top;
  typedef struct {logic [31:0] a; logic w; logic [3:0] rq; logic [31:0] ma; int lat;} prc_row_s;
  logic        core_clk = 1'b0, rst_n = 1'b0, valid = 1'b0, wr = 1'b0, swap = 1'b0;
  logic        aok, rdy_n, swapped, mwr;
  logic [31:0] addr = 32'h0, module_addr;
  wire  [3:0]  rq_n, ok;
  logic [3:0]  wt = 4'h0;
  int          err_count = 0, checks_done = 0, n_rdy = 0;
  prc_row_s    rows[9] = '{
    '{32'h00001000, 1'b0, 4'h7, 32'h00001000, 5}, '{32'h00001004, 1'b1, 4'h7, 32'h00001004, 4},
    '{32'h08000000, 1'b0, 4'hb, 32'h08000000, 6}, '{32'h40000010, 1'b1, 4'hb, 32'h40000010, 4},
    '{32'hc0000020, 1'b0, 4'hd, 32'hc0000020, 4}, '{32'he0000020, 1'b0, 4'hd, 32'hc0000020, 4},
    '{32'hfffff000, 1'b0, 4'hd, 32'hdffff000, 4}, '{32'ha0000040, 1'b0, 4'he, 32'ha0000040, 4},
    '{32'hb8000000, 1'b1, 4'he, 32'hb8000000, 4}};
  // Latency: edges from the taking edge until ready is seen low; the request
  // leaves one edge after the entry lands in the queue

  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (rdy_n === 1'b0) n_rdy++;

  prc_coordinator dut (
    .core_clk(core_clk), .rst_n(rst_n), .proc_addr_valid(valid), .proc_addr(addr),
    .proc_write(wr), .proc_addr_ok(aok), .proc_ready_n(rdy_n), .map_swap(swap),
    .map_swapped(swapped), .module_addr(module_addr), .module_write(mwr),
    .hotline_mem_request_n(rq_n[3]), .hotline_mem_next_ok(ok[3]),
    .global_bus_request_n(rq_n[2]), .global_bus_next_ok(ok[2]),
    .subsystem_request_n(rq_n[1]), .subsystem_next_ok(ok[1]),
    .workstation_if_request_n(rq_n[0]), .workstation_if_next_ok(ok[0]));
  for (genvar g = 0; g < 4; g++) begin : g_mod
    prc_target_model m (.core_clk(core_clk), .rst_n(rst_n), .request_n(rq_n[g]),
                        .wait_cycles(wt), .next_ok(ok[g]));
  end

  task automatic conclude();
    $display("checks_done=%0d err_count=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  task automatic issue(input logic [31:0] a, input logic w);
    valid <= 1'b1;
    addr  <= a;
    wr    <= w;
    do @(posedge core_clk); while (aok !== 1'b1);
  endtask : issue

  task automatic run(input prc_row_s r);
    logic [3:0]  seen;
    logic [31:0] got;
    logic        gw;
    int          lat;
    seen = 4'hf;
    got = 32'h0;
    gw = 1'b0;
    lat = 0;
    issue(r.a, r.w);
    valid <= 1'b0;
    do begin
      @(posedge core_clk);
      lat++;
      if (seen === 4'hf) begin
        seen = rq_n;
        got = module_addr;
        gw = mwr;
      end
    end while (rdy_n !== 1'b0 && lat < 30);
    `CHK(seen, r.rq)
    `CHK(got, r.ma)
    `CHK(gw, r.w)
    `CHK(lat, r.lat)
  endtask : run

  initial begin
    #20000;
    err_count++;
    conclude();
  end

  initial begin
    repeat (5) @(posedge core_clk);
    `CHK(rq_n, 4'hf)
    `CHK(aok, 1'b1)
    rst_n <= 1'b1;
    foreach (rows[i]) run(rows[i]);
    // ----------------------------------------------------------------
    // Queue full with slow modules: fourth cycle must wait
    // ----------------------------------------------------------------
    wt <= 4'h6;
    // Let the last row's ready pulse pass before counting
    @(posedge core_clk);
    n_rdy = 0;
    issue(32'h00000100, 1'b0);
    issue(32'hc0000000, 1'b1);
    issue(32'h08000000, 1'b0);
    addr <= 32'h00000200;
    repeat (2) @(posedge core_clk);
    `CHK(aok, 1'b0)
    do @(posedge core_clk); while (aok !== 1'b1);
    valid <= 1'b0;
    repeat (40) @(posedge core_clk);
    `CHK(n_rdy, 4)
    // ----------------------------------------------------------------
    // Map swap, then a mid-run reset restores the alias
    // ----------------------------------------------------------------
    wt <= 4'h0;
    run(prc_row_s'{32'h07ffff00, 1'b1, 4'h7, 32'h07ffff00, 4});
    swap <= 1'b1;
    @(posedge core_clk);
    swap <= 1'b0;
    repeat (2) @(posedge core_clk);
    `CHK(swapped, 1'b1)
    run(prc_row_s'{32'hfffff000, 1'b0, 4'h7, 32'h07fff000, 5});
    issue(32'h08000000, 1'b0);
    valid <= 1'b0;
    @(posedge core_clk);
    rst_n <= 1'b0;
    @(posedge core_clk);
    `CHK(rq_n, 4'hf)
    `CHK(swapped, 1'b0)
    rst_n <= 1'b1;
    run(rows[6]);
    conclude();
  end
endmodule : prc_coordinator_tb_top

// [dv/prc_target_model.sv]
// Model of one target module: answers each request with a next-ok pulse.
// Assumes the coordinator's clock; the bench sets the wait before the pulse.
`timescale 1ns/100ps
module prc_target_model (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       request_n,
  input  wire logic [3:0] wait_cycles,
  output logic            next_ok
);
  logic [3:0] cnt_reg;

  // One pulse per request unit, never while not requested
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 4'h0;
      next_ok <= 1'b0;
    end else if (next_ok) begin
      cnt_reg <= 4'h0;
      next_ok <= 1'b0;
    end else if (!request_n) begin
      if (cnt_reg >= wait_cycles)
        next_ok <= 1'b1;
      else
        cnt_reg <= cnt_reg + 4'h1;
    end
  end
endmodule : prc_target_model

// [hw/prc_coordinator.sv]
// Processor request coordinator: queues processor cycles, routes them to
// hotline memory, global bus, subsystem or workstation interface.
// Assumes all modules and the processor run on core_clk; next-ok inputs
// are one-cycle pulses from same-clock logic.
`timescale 1ns/100ps

// What this block does
// - Decode address bits 31..27 to pick target
// - Subsystem also at alias base after reset
// - Reset vector fetch reaches boot ROM
// - Swap signal maps hotline end to top
// - Hold up to three outstanding requests
// - Three-deep two-bit cycle type queue
// - One active-low request per target module
// - Remote memory via arbitrator, others direct
// - Bus read ready three cycles after ack
// - Hotline read ready two cycles after ack
// - Other accesses ready one cycle after ack
// - Request, wait ack, then next queued address
// - Next memory cycle may follow ack directly
module prc_coordinator #(
  parameter logic [4:0] WS_BASE_CODE  = 5'h14,
  parameter logic [4:0] HOT_BASE_CODE = prc_pkg::HOTLINE_CODE,
  parameter logic [4:0] SUB_CODE      = prc_pkg::SUB_BASE_CODE,
  parameter logic [4:0] ALIAS_CODE    = prc_pkg::ALIAS_BASE_CODE
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        proc_addr_valid,
  input  wire logic [31:0] proc_addr,
  input  wire logic        proc_write,
  output logic             proc_addr_ok,
  output logic             proc_ready_n,
  input  wire logic        map_swap,
  output logic             map_swapped,
  output logic [31:0]      module_addr,
  output logic             module_write,
  output logic             hotline_mem_request_n,
  input  wire logic        hotline_mem_next_ok,
  output logic             global_bus_request_n,
  input  wire logic        global_bus_next_ok,
  output logic             subsystem_request_n,
  input  wire logic        subsystem_next_ok,
  output logic             workstation_if_request_n,
  input  wire logic        workstation_if_next_ok
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic logic [1:0] target_of(input logic [31:0] addr, input logic swapped);
    logic [4:0] code;
    code = addr[31:27];
    if (swapped && code == prc_pkg::TOP_CODE)
      target_of = prc_pkg::TGT_HOTLINE;
    else if (code == HOT_BASE_CODE)
      target_of = prc_pkg::TGT_HOTLINE;
    else if ((code & prc_pkg::QUARTER_MASK) == SUB_CODE)
      target_of = prc_pkg::TGT_SUB;
    else if (!swapped && (code & prc_pkg::QUARTER_MASK) == ALIAS_CODE)
      target_of = prc_pkg::TGT_SUB;
    else if ((code & prc_pkg::QUARTER_MASK) == WS_BASE_CODE)
      target_of = prc_pkg::TGT_WS;
    else
      target_of = prc_pkg::TGT_BUS;
  endfunction : target_of

  function automatic logic [31:0] mapped_of(input logic [31:0] addr, input logic swapped);
    logic [4:0] code;
    code = addr[31:27];
    if (swapped && code == prc_pkg::TOP_CODE)
      mapped_of = {HOT_BASE_CODE, addr[26:0]};
    else if (!swapped && (code & prc_pkg::QUARTER_MASK) == ALIAS_CODE)
      mapped_of = {SUB_CODE[4:2], addr[28:0]};
    else
      mapped_of = addr;
  endfunction : mapped_of

  // ----------------------------------------------------------------
  // Queue storage
  // ----------------------------------------------------------------
  logic [31:0]               q_addr_reg  [prc_pkg::QUEUE_DEPTH];
  logic                      q_write_reg [prc_pkg::QUEUE_DEPTH];
  logic [1:0]                q_tgt_reg   [prc_pkg::QUEUE_DEPTH];
  logic [1:0]                q_type_reg  [prc_pkg::QUEUE_DEPTH];
  logic [1:0]                wr_ptr_reg;
  logic [1:0]                rd_ptr_reg;
  prc_pkg::prc_q_state_e     q_state_reg;
  prc_pkg::prc_q_state_e     q_state_next;
  prc_pkg::prc_req_state_e   req_state_reg;
  logic                      map_swapped_reg;
  logic [2:0]                ready_sched_reg;
  logic [1:0]                cur_tgt_reg;
  logic                      push;
  logic                      pop;
  logic                      ack;
  logic [1:0]                new_tgt;
  logic [1:0]                rd_ptr_inc;
  logic [1:0]                delay;

  function automatic logic [1:0] ptr_inc(input logic [1:0] p);
    ptr_inc = (p == 2'(prc_pkg::QUEUE_DEPTH - 1)) ? 2'h0 : p + 2'h1;
  endfunction : ptr_inc

  // Slot frees on next-ok, since the address is no longer needed then
  assign push       = proc_addr_valid && proc_addr_ok;
  assign new_tgt    = target_of(proc_addr, map_swapped_reg);
  assign rd_ptr_inc = ptr_inc(rd_ptr_reg);

  always_comb begin
    unique case (cur_tgt_reg)
      prc_pkg::TGT_HOTLINE: ack = hotline_mem_next_ok;
      prc_pkg::TGT_BUS:     ack = global_bus_next_ok;
      prc_pkg::TGT_SUB:     ack = subsystem_next_ok;
      prc_pkg::TGT_WS:      ack = workstation_if_next_ok;
    endcase
  end

  assign pop = (req_state_reg == prc_pkg::PRC_REQ_WAIT) && ack;

  // ----------------------------------------------------------------
  // Cycle type queue and occupancy machine
  // ----------------------------------------------------------------
  always_comb begin
    q_state_next = q_state_reg;
    if (push && !pop)
      q_state_next = prc_pkg::prc_q_state_e'(q_state_reg + 2'h1);
    else if (pop && !push)
      q_state_next = prc_pkg::prc_q_state_e'(q_state_reg - 2'h1);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q_state_reg  <= prc_pkg::PRC_Q_EMPTY;
      proc_addr_ok <= 1'b1;
      wr_ptr_reg   <= 2'h0;
      rd_ptr_reg   <= 2'h0;
    end else begin
      q_state_reg  <= q_state_next;
      proc_addr_ok <= (q_state_next != prc_pkg::PRC_Q_FULL);
      if (push)
        wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      if (pop)
        rd_ptr_reg <= rd_ptr_inc;
    end
  end

  // Entries hold no control state, so they need no reset
  always_ff @(posedge core_clk) begin
    if (push) begin
      q_addr_reg[wr_ptr_reg]  <= mapped_of(proc_addr, map_swapped_reg);
      q_write_reg[wr_ptr_reg] <= proc_write;
      q_tgt_reg[wr_ptr_reg]   <= new_tgt;
      if (proc_write)
        q_type_reg[wr_ptr_reg] <= prc_pkg::CT_OTHER;
      else if (new_tgt == prc_pkg::TGT_BUS)
        q_type_reg[wr_ptr_reg] <= prc_pkg::CT_BUS_READ;
      else if (new_tgt == prc_pkg::TGT_HOTLINE)
        q_type_reg[wr_ptr_reg] <= prc_pkg::CT_HOT_READ;
      else
        q_type_reg[wr_ptr_reg] <= prc_pkg::CT_OTHER;
    end
  end

  // ----------------------------------------------------------------
  // Map swap
  // ----------------------------------------------------------------
  // Sticky until reset; the boot alias cannot be brought back by software
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      map_swapped_reg <= 1'b0;
    else if (map_swap)
      map_swapped_reg <= 1'b1;
  end

  assign map_swapped = map_swapped_reg;

  // ----------------------------------------------------------------
  // Request control
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_state_reg            <= prc_pkg::PRC_REQ_IDLE;
      cur_tgt_reg              <= prc_pkg::TGT_HOTLINE;
      module_addr              <= 32'h0000_0000;
      module_write             <= 1'b0;
      hotline_mem_request_n    <= 1'b1;
      global_bus_request_n     <= 1'b1;
      subsystem_request_n      <= 1'b1;
      workstation_if_request_n <= 1'b1;
    end else begin
      unique case (req_state_reg)
        prc_pkg::PRC_REQ_IDLE: begin
          if (q_state_reg != prc_pkg::PRC_Q_EMPTY) begin
            req_state_reg            <= prc_pkg::PRC_REQ_WAIT;
            cur_tgt_reg              <= q_tgt_reg[rd_ptr_reg];
            module_addr              <= q_addr_reg[rd_ptr_reg];
            module_write             <= q_write_reg[rd_ptr_reg];
            hotline_mem_request_n    <= q_tgt_reg[rd_ptr_reg] != prc_pkg::TGT_HOTLINE;
            global_bus_request_n     <= q_tgt_reg[rd_ptr_reg] != prc_pkg::TGT_BUS;
            subsystem_request_n      <= q_tgt_reg[rd_ptr_reg] != prc_pkg::TGT_SUB;
            workstation_if_request_n <= q_tgt_reg[rd_ptr_reg] != prc_pkg::TGT_WS;
          end
        end
        prc_pkg::PRC_REQ_WAIT: begin
          if (ack && q_state_reg != prc_pkg::PRC_Q_ONE) begin
            // Overlap: next entry goes out right after the ack
            cur_tgt_reg              <= q_tgt_reg[rd_ptr_inc];
            module_addr              <= q_addr_reg[rd_ptr_inc];
            module_write             <= q_write_reg[rd_ptr_inc];
            hotline_mem_request_n    <= q_tgt_reg[rd_ptr_inc] != prc_pkg::TGT_HOTLINE;
            global_bus_request_n     <= q_tgt_reg[rd_ptr_inc] != prc_pkg::TGT_BUS;
            subsystem_request_n      <= q_tgt_reg[rd_ptr_inc] != prc_pkg::TGT_SUB;
            workstation_if_request_n <= q_tgt_reg[rd_ptr_inc] != prc_pkg::TGT_WS;
          end else if (ack) begin
            req_state_reg            <= prc_pkg::PRC_REQ_IDLE;
            hotline_mem_request_n    <= 1'b1;
            global_bus_request_n     <= 1'b1;
            subsystem_request_n      <= 1'b1;
            workstation_if_request_n <= 1'b1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Ready generator
  // ----------------------------------------------------------------
  always_comb begin
    unique case (q_type_reg[rd_ptr_reg])
      prc_pkg::CT_BUS_READ: delay = prc_pkg::BUS_READ_DELAY;
      prc_pkg::CT_HOT_READ: delay = prc_pkg::HOT_READ_DELAY;
      default:              delay = prc_pkg::OTHER_DELAY;
    endcase
  end

  // Schedule bit k fires ready k+1 cycles after the ack; two acks whose
  // deadlines coincide merge into one ready, a known limitation
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_sched_reg <= 3'h0;
      proc_ready_n    <= 1'b1;
    end else begin
      ready_sched_reg <= {1'b0, ready_sched_reg[2:1]} |
                         (pop ? (3'h1 << (delay - 2'h1)) : 3'h0);
      proc_ready_n    <= !((pop && delay == prc_pkg::OTHER_DELAY) ||
                           ready_sched_reg[1]);
    end
  end

endmodule : prc_coordinator

// [hw/prc_pkg.sv]
// Constants shared by the processor request coordinator.
// Assumes a 32-bit processor address whose top five bits select a region.
package prc_pkg;

  // ----------------------------------------------------------------
  // Widths and queue depth
  // ----------------------------------------------------------------
  localparam int          ADDR_W        = 32;
  localparam int          CODE_W        = 5;
  localparam int          CODE_LSB      = 27;
  localparam int          QUEUE_DEPTH   = 3;
  localparam int          CYCLE_TYPE_W  = 2;

  // ----------------------------------------------------------------
  // Region codes, address bits 31..27
  // ----------------------------------------------------------------
  localparam logic [4:0]  HOTLINE_CODE    = 5'h00;
  localparam logic [4:0]  SUB_BASE_CODE   = 5'h18;
  localparam logic [4:0]  ALIAS_BASE_CODE = 5'h1c;
  localparam logic [4:0]  TOP_CODE        = 5'h1f;
  localparam logic [4:0]  QUARTER_MASK    = 5'h1c;
  localparam logic [31:0] RESET_VECTOR    = 32'hfffff000;

  // ----------------------------------------------------------------
  // Targets and cycle types
  // ----------------------------------------------------------------
  localparam logic [1:0]  TGT_HOTLINE  = 2'h0;
  localparam logic [1:0]  TGT_BUS      = 2'h1;
  localparam logic [1:0]  TGT_SUB      = 2'h2;
  localparam logic [1:0]  TGT_WS       = 2'h3;
  localparam logic [1:0]  CT_OTHER     = 2'h0;
  localparam logic [1:0]  CT_HOT_READ  = 2'h1;
  localparam logic [1:0]  CT_BUS_READ  = 2'h2;

  // ----------------------------------------------------------------
  // Ready delays after next-address-ok, in core_clk cycles
  // ----------------------------------------------------------------
  localparam logic [1:0]  BUS_READ_DELAY = 2'h3;
  localparam logic [1:0]  HOT_READ_DELAY = 2'h2;
  localparam logic [1:0]  OTHER_DELAY    = 2'h1;

  typedef enum logic [0:0] {
    PRC_REQ_IDLE = 1'b0,
    PRC_REQ_WAIT = 1'b1
  } prc_req_state_e;

  typedef enum logic [1:0] {
    PRC_Q_EMPTY = 2'b00,
    PRC_Q_ONE   = 2'b01,
    PRC_Q_TWO   = 2'b10,
    PRC_Q_FULL  = 2'b11
  } prc_q_state_e;

endpackage : prc_pkg
